// >>> rtl/scsi_ack_timing_controller.sv
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module scsi_ack_timing_controller
    import scsi_ack_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic req_i,
    input wire logic ack_latched_i,
    input wire logic io_in_i,
    input wire logic offset_nonzero_i,
    input wire logic fifo_half_full_flag_i,
    input wire logic fifo_data_avail_i,
    output logic ack_o,
    output logic ack_bypass_en_o,
    output logic count_down_o,
    output logic fifo_strobe_o,
    output logic xmit_load_o
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // least cycles from transmit load to ACK for the mode
    function automatic logic [3:0] min_ack_cycles(input logic sync,
                                                  input logic [3:0] load);
        logic [3:0] r;
        r = ASYNC_MIN_CYC;
        if (sync) begin
            r = (load >= FAST_SYNC_MIN_LOAD) ? FAST_MIN_CYC : SYNC_MIN_CYC;
        end
        return r;
    endfunction

    function automatic logic [3:0] sat_inc(input logic [3:0] v);
        return (v == 4'hf) ? v : v + 4'h1;
    endfunction

    core_t st_ff;
    core_t nxt_st;
    logic req;
    logic ackl;
    logic io;
    logic ofs;
    logic hf;
    logic avail;
    logic sync;
    logic rd_busy;

    // synchronised pins, second stage only
    assign req = st_ff.pin_sync[PIN_REQ];
    assign ackl = st_ff.pin_sync[PIN_ACKL];
    assign io = st_ff.pin_sync[PIN_IO];
    assign ofs = st_ff.pin_sync[PIN_OFS];
    assign hf = st_ff.pin_sync[PIN_HF];
    assign avail = st_ff.pin_sync[PIN_AVAIL];
    assign sync = st_ff.ctrl.sync_mode;
    assign rd_busy = st_ff.fifo_read_active | st_ff.async_fifo_read_start |
                     st_ff.sync_fifo_read_start;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic dly_call;
        logic [3:0] load_sel;
        logic since_ok;
        nxt_st = st_ff;
        dly_call = 1'b0;
        load_sel = sync ? st_ff.ctrl.load_value : ASYNC_LOAD_VALUE;
        since_ok = st_ff.rd_cycle ||
                   (st_ff.since_load >= min_ack_cycles(sync, st_ff.ctrl.load_value));

        // two-flop pin synchronisers
        nxt_st.pin_meta = {fifo_data_avail_i, fifo_half_full_flag_i,
                           offset_nonzero_i, io_in_i, ack_latched_i, req_i};
        nxt_st.pin_sync = st_ff.pin_meta;

        // register writes
        if (reg_wr_i && reg_addr_i == CTRL_ADDR) begin
            nxt_st.ctrl.sync_mode = reg_wdata_i[CTRL_SYNC_BIT];
            nxt_st.ctrl.load_value = reg_wdata_i[CTRL_LOAD_LSB +: 4];
        end

        // register reads, data valid one cycle later
        nxt_st.rdata = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                CTRL_ADDR: begin
                    nxt_st.rdata = {st_ff.ctrl.load_value, 3'h0, st_ff.ctrl.sync_mode};
                end
                STATUS_ADDR: begin
                    nxt_st.rdata = {st_ff.ack_state, st_ff.xmit_valid,
                                    st_ff.fifo_read_active, st_ff.delay_run,
                                    st_ff.echo, st_ff.ack_out};
                end
                default: begin
                    nxt_st.rdata = 8'h00;
                end
            endcase
        end

        // fifo read starts, one cycle each
        nxt_st.async_fifo_read_start = !io && !sync && avail && !rd_busy;
        nxt_st.sync_fifo_read_start = !io && sync && avail && ofs && !rd_busy;

        // read active holds the strobe until the end state
        if (st_ff.async_fifo_read_start || st_ff.sync_fifo_read_start) begin
            nxt_st.fifo_read_active = 1'b1;
        end else if (st_ff.fifo_read_end_state) begin
            nxt_st.fifo_read_active = 1'b0;
        end

        // strobe delay states
        if (!st_ff.fifo_read_active) begin
            nxt_st.strb_dly = 2'h0;
        end else if (st_ff.strb_dly != STRB_DLY_STATES) begin
            nxt_st.strb_dly = st_ff.strb_dly + 2'h1;
        end

        // end state once delay met and transmit register empty
        nxt_st.fifo_read_end_state = st_ff.fifo_read_active &&
                                     st_ff.strb_dly == STRB_DLY_STATES &&
                                     !st_ff.xmit_valid &&
                                     !st_ff.fifo_read_end_state;
        if (st_ff.fifo_read_end_state) begin
            nxt_st.xmit_valid = 1'b1;
        end

        // cycles since the transmit register was loaded
        // saturates so a long idle never wraps into a short gap
        nxt_st.since_load = st_ff.fifo_read_end_state ? 4'h0 : sat_inc(st_ff.since_load);

        // ack sequencer
        nxt_st.down_state = 1'b0;
        case (st_ff.ack_state)
            A_IDLE: begin
                if (!io && (st_ff.fifo_read_end_state || st_ff.xmit_valid)) begin
                    nxt_st.ack_state = A_FILL;
                end else if (io && sync && !hf && ofs) begin
                    nxt_st.ack_state = A_RDST;
                    nxt_st.rd_cycle = 1'b1;
                end
            end
            A_RDST: begin
                nxt_st.ack_state = A_FILL;
            end
            A_FILL: begin
                // fill state, then the delay load follows
                dly_call = 1'b1;
                nxt_st.down_state = st_ff.rd_cycle;
                nxt_st.ack_state = A_DLY1;
            end
            A_DLY1: begin
                if (st_ff.delay_exit_state) begin
                    nxt_st.dly_done = 1'b1;
                end
                if ((st_ff.delay_exit_state || st_ff.dly_done) && since_ok) begin
                    nxt_st.ack_state = A_ACK;
                    nxt_st.dly_done = 1'b0;
                    dly_call = sync;
                end
            end
            A_ACK: begin
                if (sync) begin
                    if (st_ff.delay_exit_state) begin
                        nxt_st.ack_state = A_STR1;
                    end
                end else if (ackl && !req) begin
                    nxt_st.ack_state = A_TERM;
                end
            end
            A_STR1: begin
                nxt_st.ack_state = A_STR2;
            end
            A_STR2: begin
                nxt_st.ack_state = A_IDLE;
                nxt_st.xmit_valid = st_ff.rd_cycle ? st_ff.xmit_valid : 1'b0;
                nxt_st.rd_cycle = 1'b0;
            end
            A_TERM: begin
                nxt_st.ack_state = A_IDLE;
                nxt_st.xmit_valid = 1'b0;
            end
            default: begin
                nxt_st.ack_state = A_IDLE;
            end
        endcase

        // delay counter: load-enable states, count, exit
        nxt_st.delay_exit_state = 1'b0;
        nxt_st.delay_load_pend = dly_call;
        nxt_st.delay_load_enable = dly_call ? load_sel : 4'h0;
        if (st_ff.delay_load_pend) begin
            nxt_st.delay_count = st_ff.delay_load_enable;
            nxt_st.delay_run = 1'b1;
        end else if (st_ff.delay_run) begin
            if (st_ff.delay_count == COUNT_FULL) begin
                nxt_st.delay_run = 1'b0;
                nxt_st.delay_exit_state = 1'b1;
            end else begin
                nxt_st.delay_count = st_ff.delay_count + 4'h1;
            end
        end

        // async read echo, held at half full until req drops
        // a held echo keeps ack up even if half full rises mid-beat
        if (st_ff.echo) begin
            nxt_st.echo = req && !sync;
        end else begin
            nxt_st.echo = io && !sync && req && !hf;
        end

        // registered outputs
        nxt_st.ack_out = nxt_st.ack_state == A_ACK || nxt_st.ack_state == A_STR1 ||
                         nxt_st.ack_state == A_STR2 || nxt_st.echo;
        nxt_st.strobe_out = nxt_st.async_fifo_read_start ||
                            nxt_st.sync_fifo_read_start || nxt_st.fifo_read_active;
        nxt_st.down_out = sync && (nxt_st.down_state || nxt_st.fifo_read_active);
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            // load value resets to the shortest sync delay
            st_ff <= '0;
            st_ff.ctrl.load_value <= LOAD_VALUE_RST;
            st_ff.ack_state <= A_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs from flops
    assign reg_rdata_o = st_ff.rdata;
    assign ack_o = st_ff.ack_out;
    assign ack_bypass_en_o = st_ff.ctrl.sync_mode;
    assign count_down_o = st_ff.down_out;
    assign fifo_strobe_o = st_ff.strobe_out;
    assign xmit_load_o = st_ff.fifo_read_end_state;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_delay_exit_full: assert property (
        st_ff.delay_run && !st_ff.delay_load_pend && st_ff.delay_count == COUNT_FULL
        |=> st_ff.delay_exit_state && !st_ff.delay_run)
        else $error("delay exit missed at full count");

    a_delay_load_val: assert property (
        st_ff.delay_load_pend |=> st_ff.delay_run &&
        st_ff.delay_count == $past(st_ff.delay_load_enable))
        else $error("delay counter not loaded from enables");

    a_fill_then_load: assert property (
        st_ff.ack_state == A_FILL |=> st_ff.delay_load_pend ##1 st_ff.delay_run)
        else $error("fill state not followed by delay load");

    a_async_ack_gap: assert property (
        $rose(st_ff.ack_state == A_ACK) && !sync && !st_ff.rd_cycle
        |-> st_ff.since_load >= ASYNC_MIN_CYC)
        else $error("async ack raised too early");

    a_async_term: assert property (
        st_ff.ack_state == A_ACK && !sync && ackl && !req
        |=> st_ff.ack_state == A_TERM ##1 !st_ff.xmit_valid)
        else $error("async ack not terminated");

    a_echo_hold: assert property (
        st_ff.echo && req && !sync |=> st_ff.echo && ack_o)
        else $error("echoed ack dropped while req held");

    a_end_loads: assert property (
        st_ff.fifo_read_end_state |-> !st_ff.xmit_valid ##1
        (st_ff.xmit_valid && !st_ff.fifo_read_active))
        else $error("read end did not fill transmit register");

    a_down_pulse: assert property (
        st_ff.ack_state == A_FILL && st_ff.rd_cycle && sync |=> count_down_o)
        else $error("count-down pulse missing on read ack");

    a_strobe_min: assert property (
        $rose(st_ff.fifo_read_active) |-> fifo_strobe_o [*3])
        else $error("fifo strobe shorter than minimum");

    a_strobe_during_read: assert property (
        st_ff.fifo_read_active |-> fifo_strobe_o)
        else $error("fifo strobe low during active read");

    a_async_load_val: assert property (
        st_ff.ack_state == A_FILL && !sync |=> st_ff.delay_load_enable == ASYNC_LOAD_VALUE)
        else $error("async delay not loaded with fixed value");

    a_sync_second_dly: assert property (
        $rose(st_ff.ack_state == A_ACK) && sync |-> st_ff.delay_load_pend)
        else $error("sync ack did not start second delay");

    a_sync_ack_stretch: assert property (
        st_ff.ack_state == A_STR1 |=> st_ff.ack_state == A_STR2 && ack_o)
        else $error("sync ack stretch missing");

    a_term_clears_ack: assert property (
        st_ff.ack_state == A_TERM && !st_ff.echo |-> !ack_o)
        else $error("ack still high in terminate state");

    a_echo_start: assert property (
        !st_ff.echo && io && !sync && req && !hf |=> st_ff.echo && ack_o)
        else $error("req not echoed as ack");

    a_half_full_block: assert property (
        !st_ff.echo && hf |=> !st_ff.echo)
        else $error("echo started while half full");

endmodule

// >>> rtl/scsi_ack_pkg.sv
package scsi_ack_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int ASYNC_WR_DELAY_NS = 60;
    localparam int FAST_WR_DELAY_NS = 40;
    localparam int SYNC_WR_DELAY_NS = 90;
    // least times round up to whole cycles
    localparam logic [3:0] ASYNC_MIN_CYC =
        4'((ASYNC_WR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] FAST_MIN_CYC =
        4'((FAST_WR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] SYNC_MIN_CYC =
        4'((SYNC_WR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [1:0] STRB_DLY_STATES = 2'h2;

    // ----------------------------------------
    // delay counter values
    // ----------------------------------------
    localparam logic [3:0] COUNT_FULL = 4'hf;
    localparam logic [3:0] ASYNC_LOAD_VALUE = 4'hd;
    localparam logic [3:0] FAST_SYNC_MIN_LOAD = 4'hb;
    localparam logic [3:0] LOAD_VALUE_RST = 4'hf;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h1;
    localparam int CTRL_SYNC_BIT = 0;
    localparam int CTRL_LOAD_LSB = 4;

    // ----------------------------------------
    // synchronised pin positions
    // ----------------------------------------
    localparam int PIN_REQ = 0;
    localparam int PIN_ACKL = 1;
    localparam int PIN_IO = 2;
    localparam int PIN_OFS = 3;
    localparam int PIN_HF = 4;
    localparam int PIN_AVAIL = 5;
    localparam int PIN_N = 6;

    typedef enum logic [2:0] {
        A_IDLE = 3'b000,
        A_FILL = 3'b001,
        A_DLY1 = 3'b011,
        A_ACK = 3'b010,
        A_STR1 = 3'b110,
        A_STR2 = 3'b111,
        A_TERM = 3'b100,
        A_RDST = 3'b101
    } ack_state_t;

    typedef struct packed {
        logic [3:0] load_value;
        logic sync_mode;
    } ctrl_t;

    typedef struct packed {
        logic [PIN_N-1:0] pin_meta;
        logic [PIN_N-1:0] pin_sync;
        ctrl_t ctrl;
        logic [7:0] rdata;
        ack_state_t ack_state;
        logic async_fifo_read_start;
        logic sync_fifo_read_start;
        logic fifo_read_active;
        logic [1:0] strb_dly;
        logic fifo_read_end_state;
        logic xmit_valid;
        logic [3:0] since_load;
        logic rd_cycle;
        logic down_state;
        logic [3:0] delay_load_enable;
        logic delay_load_pend;
        logic [3:0] delay_count;
        logic delay_run;
        logic delay_exit_state;
        logic dly_done;
        logic echo;
        logic ack_out;
        logic strobe_out;
        logic down_out;
    } core_t;

endpackage

// >>> bench/scsi_target_model.sv
`timescale 1ns/10ps
module scsi_target_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ack_i,
    input wire logic bypass_i,
    input wire logic count_down_i,
    input wire logic go_i,
    input wire logic slow_i,
    output logic req_o,
    output logic ack_latched_o,
    output logic offset_nonzero_o
);
    logic lat_ff;
    logic cd_q;
    int dly;
    int ups;
    int dns;

    // latch lets ack out only once req is up; sync mode bypasses it
    assign ack_latched_o = bypass_i ? ack_i : lat_ff;
    assign offset_nonzero_o = (ups > dns);

    // target handshake and outstanding offset count
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lat_ff <= 1'b0;
            req_o <= 1'b0;
            cd_q <= 1'b0;
            dly <= 0;
            ups <= 0;
            dns <= 0;
        end else begin
            lat_ff <= ack_i & (req_o | lat_ff);
            cd_q <= count_down_i;
            if (count_down_i && !cd_q && ups > dns) dns <= dns + 1;
            if (dly > 0) dly <= dly - 1;
            else if (bypass_i) begin
                // sync: two-cycle req pulses, at most four outstanding
                if (req_o) begin
                    req_o <= 1'b0;
                    dly <= slow_i ? 6 : 2;
                end else if (go_i && ups - dns < 4) begin
                    req_o <= 1'b1;
                    dly <= 1;
                    ups <= ups + 1;
                end
            end else if (req_o && ack_latched_o) begin
                req_o <= 1'b0;
                dly <= slow_i ? 7 : 0;
            end else if (!req_o && !ack_latched_o && go_i) begin
                req_o <= 1'b1;
                dly <= slow_i ? 7 : 0;
            end
        end
    end
endmodule

// >>> bench/tb.sv
`timescale 1ns/10ps
module tb
    import scsi_ack_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b, wr, rd, req, ackl, io, onz, hf, av, ack, byp, cd, strb, xld, go, slow, ack_q, cd_q, term;
    logic [3:0] addr, ld;
    logic [7:0] wd, rdat, d, r;
    int mismatches, checks, seed, gap, min_gap, acks, cds, xlds, hi_w, last_w, mode, wf, a0, c0, x0;

    scsi_ack_timing_controller u_scsi_ack_timing_controller (
        .clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdat), .req_i(req), .ack_latched_i(ackl), .io_in_i(io),
        .offset_nonzero_i(onz), .fifo_half_full_flag_i(hf), .fifo_data_avail_i(av), .ack_o(ack),
        .ack_bypass_en_o(byp), .count_down_o(cd), .fifo_strobe_o(strb), .xmit_load_o(xld));

    scsi_target_model u_scsi_target_model (
        .clk_i(clk), .rst_b_i(rst_b), .ack_i(ack), .bypass_i(byp), .count_down_i(cd),
        .go_i(go), .slow_i(slow), .req_o(req), .ack_latched_o(ackl), .offset_nonzero_o(onz));

    // 125 MHz clock
    always #4 clk = ~clk;

    task automatic check_val(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_bit(input string name, input logic exp, input logic got);
        check_val(name, {7'h00, exp}, {7'h00, got});
    endtask

    task automatic tally_and_finish();
        if (mismatches == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    function automatic logic [7:0] ctrl_exp(input logic [7:0] w);
        ctrl_exp = 8'h00;
        ctrl_exp[7:4] = w[7:4];
        ctrl_exp[CTRL_SYNC_BIT] = w[CTRL_SYNC_BIT];
    endfunction

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        addr <= a;
        wd <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        v = rdat;
    endtask

    task automatic run_acks(input int n);
        int t;
        t = acks + n;
        for (int i = 0; i < 4000 && acks < t; i++) @(posedge clk);
        check_bit("ack_progress", 1'b1, acks >= t);
    endtask

    task automatic drain();
        mode = 0;
        av <= 1'b0;
        repeat (300) @(posedge clk);
    endtask

    // watch acknowledge shape, gaps and pulse counts
    always @(posedge clk) begin
        gap = xld ? 0 : gap + 1;
        if (ackl && !req) term = 1'b1;
        if (ack && !ack_q) begin
            acks++;
            term = 1'b0;
            if (mode == 1 || mode == 2) check_bit("ack_gap", 1'b1, gap >= min_gap);
            if (mode == 3) check_bit("ack_echo", 1'b1, req);
        end
        if (ack) hi_w++;
        else if (ack_q) begin
            last_w = hi_w;
            hi_w = 0;
            if (mode == 1) check_bit("ack_term", 1'b1, term);
        end
        if (xld && mode == 1) check_bit("load_idle", 1'b0, ack);
        if (cd && !cd_q) cds++;
        if (xld) xlds++;
        ack_q = ack;
        cd_q = cd;
    end

    // hang guard
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        seed = 86;
        {rst_b, wr, rd, io, hf, av, go, slow, ack_q, cd_q, term} = '0;
        addr = '0;
        wd = '0;
        {checks, mismatches, gap, acks, cds, xlds, hi_w, last_w, mode, min_gap} = '0;
        repeat (5) @(posedge clk);
        check_val("idle_out", 8'h00, {3'h0, ack, byp, cd, strb, xld});
        rst_b <= 1'b1;
        @(posedge clk);
        rd_reg(CTRL_ADDR, d);
        check_val("ctrl_rst", {LOAD_VALUE_RST, 4'h0}, d);
        rd_reg(STATUS_ADDR, d);
        check_val("status_rst", 8'h00, d);
        // random control traffic with an unmapped place among it
        for (int i = 0; i < 6; i++) begin
            wd <= 8'($random(seed));
            @(posedge clk);
            d = wd;
            wr_reg(CTRL_ADDR, d);
            wr_reg(4'h9, ~d);
            check_bit("bypass", d[CTRL_SYNC_BIT], byp);
            rd_reg(CTRL_ADDR, r);
            check_val("ctrl_rw", ctrl_exp(d), r);
            rd_reg(4'h9, d);
            check_val("unmapped", 8'h00, d);
        end
        // asynchronous writes, prompt then slow target
        wr_reg(CTRL_ADDR, {ASYNC_LOAD_VALUE, 4'h0});
        mode = 1;
        min_gap = ASYNC_MIN_CYC;
        go <= 1'b1;
        av <= 1'b1;
        run_acks(4);
        slow <= 1'b1;
        run_acks(3);
        slow <= 1'b0;
        // reset in mid transfer
        mode = 0;
        rst_b <= 1'b0;
        @(posedge clk);
        check_val("idle_mid", 8'h00, {3'h0, ack, byp, cd, strb, xld});
        rst_b <= 1'b1;
        drain();
        // synchronous writes over a spread of load values
        for (int k = 0; k < 5; k++) begin
            ld = (k == 0) ? 4'hf : (k == 1) ? 4'hb : (k == 2) ? 4'ha : (k == 3) ? 4'h1 : 4'h1;
            if (k == 4) ld = 4'h1 + 4'($unsigned($random(seed)) % 15);
            mode = 2;
            min_gap = FAST_MIN_CYC;
            av <= 1'b1;
            wr_reg(CTRL_ADDR, {ld, 4'h1});
            run_acks(1);
            min_gap = (ld >= FAST_SYNC_MIN_LOAD) ? FAST_MIN_CYC : SYNC_MIN_CYC;
            run_acks(3);
            if (k == 0) wf = last_w;
            else check_val("ack_width", 8'(wf + 15 - ld), 8'(last_w));
        end
        drain();
        // synchronous reads paced by fifo room
        io <= 1'b1;
        c0 = cds;
        a0 = acks;
        x0 = xlds;
        mode = 4;
        run_acks(4);
        hf <= 1'b1;
        repeat (100) @(posedge clk);
        check_val("down_per_ack", 8'(acks - a0), 8'(cds - c0));
        check_val("no_xmit", 8'h00, 8'(xlds - x0));
        a0 = acks;
        repeat (200) @(posedge clk);
        check_val("sync_room", 8'(a0), 8'(acks));
        // asynchronous reads echo req, held off at half full
        wr_reg(CTRL_ADDR, 8'hf0);
        hf <= 1'b0;
        mode = 3;
        run_acks(4);
        hf <= 1'b1;
        repeat (100) @(posedge clk);
        a0 = acks;
        repeat (200) @(posedge clk);
        check_val("half_full", 8'(a0), 8'(acks));
        hf <= 1'b0;
        run_acks(2);
        tally_and_finish();
    end
endmodule
